// *** inc/plc_pkg.sv ***
// Constants for the parallel line controller: register map, reset values,
// line capabilities and the timing of the input path.
// Assumes a 32-bit AXI4-Lite slave port and 32 pins shared with peripherals.
package plc_pkg;

  localparam int unsigned PLC_LINES = 32;
  localparam int unsigned PLC_ADDR_W = 8;

  // System address of the block; the interconnect decodes it
  localparam logic [31:0] PLC_BASE_ADDR = 32'hFFFF0000;

  // Register byte offsets inside the block
  localparam logic [7:0] OFF_LINE_CLAIM = 8'h00;
  localparam logic [7:0] OFF_LINE_RELEASE = 8'h04;
  localparam logic [7:0] OFF_LINE_OWNER_STATUS = 8'h08;
  localparam logic [7:0] OFF_RESERVED_A = 8'h0C;
  localparam logic [7:0] OFF_DRIVE_ENABLE_SET = 8'h10;
  localparam logic [7:0] OFF_DRIVE_ENABLE_CLEAR = 8'h14;
  localparam logic [7:0] OFF_DRIVE_ENABLE_STATUS = 8'h18;
  localparam logic [7:0] OFF_RESERVED_B = 8'h1C;
  localparam logic [7:0] OFF_GLITCH_FILTER_SET = 8'h20;
  localparam logic [7:0] OFF_GLITCH_FILTER_CLEAR = 8'h24;
  localparam logic [7:0] OFF_GLITCH_FILTER_STATUS = 8'h28;
  localparam logic [7:0] OFF_RESERVED_C = 8'h2C;
  localparam logic [7:0] OFF_LEVEL_SET = 8'h30;
  localparam logic [7:0] OFF_LEVEL_CLEAR = 8'h34;
  localparam logic [7:0] OFF_LEVEL_PROGRAM_STATUS = 8'h38;
  localparam logic [7:0] OFF_PIN_LEVEL_STATUS = 8'h3C;
  localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE = 8'h40;
  localparam logic [7:0] OFF_CHANGE_IRQ_DISABLE = 8'h44;
  localparam logic [7:0] OFF_CHANGE_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFF_CHANGE_IRQ_STATUS = 8'h4C;
  localparam logic [7:0] OFF_LAST = 8'h4C;

  // Reset values
  localparam logic [31:0] RST_LINE_OWNER = 32'h01FFFFFF;
  localparam logic [31:0] RST_DRIVE_ENABLE = 32'h00000000;
  localparam logic [31:0] RST_GLITCH_FILTER = 32'h00000000;
  localparam logic [31:0] RST_LEVEL_PROGRAM = 32'h00000000;
  localparam logic [31:0] RST_CHANGE_IRQ_MASK = 32'h00000000;
  localparam logic [31:0] RST_CHANGE_IRQ_STATUS = 32'h00000000;

  // Lines 16..19, 23 and 24 have no peripheral behind them
  localparam logic [31:0] LINES_NO_PERIPH = 32'h018F0000;

  // Glitch filters fitted on this variant
  localparam logic FILTERS_PRESENT = 1'b1;

  // Cycles after reset release before the input path holds real pin data
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : plc_pkg

// *** rtl/plc_sync.sv ***
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent asynchronous level.
`timescale 1ns/1ps
`default_nettype none
module plc_sync #(
  parameter int unsigned W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } plc_sync_state_t;

  plc_sync_state_t s;
  plc_sync_state_t next_s;

  // First stage feeds only the second stage
  always_comb begin
    next_s = s;
    next_s.stage1 = i_async;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_sync = s.stage2;

endmodule : plc_sync
`default_nettype wire

// *** rtl/plc_glitch.sv ***
// Per-line input glitch filter: with the filter on, a level passes only
// after two equal consecutive samples. Assumes synchronised inputs.
`timescale 1ns/1ps
`default_nettype none
module plc_glitch #(
  parameter int unsigned W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_level,
  input wire logic [W-1:0] i_enable,
  output logic [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] sample;
    logic [W-1:0] level;
  } plc_glitch_state_t;

  plc_glitch_state_t s;
  plc_glitch_state_t next_s;

  // One-cycle pulses are swallowed on filtered lines; costs one cycle latency
  always_comb begin
    next_s = s;
    next_s.sample = i_level;
    for (int i = 0; i < W; i++) begin
      if (!i_enable[i] || (i_level[i] == s.sample[i])) begin
        next_s.level[i] = i_level[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.level;

endmodule : plc_glitch
`default_nettype wire

// *** rtl/plc_top.sv ***
// Parallel line controller: 32 pins shared between general-purpose I/O and
// peripheral signals, with an AXI4-Lite register slave and a change interrupt.
// Assumes pins arrive asynchronously; peripheral signals share i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module plc_top
  import plc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // AXI4-Lite slave
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Pins
  input wire logic [31:0] i_pin,
  output logic [31:0] o_pin,
  output logic [31:0] o_pin_oe,
  // Peripheral side
  input wire logic [31:0] i_periph_out,
  input wire logic [31:0] i_periph_oe,
  output logic [31:0] o_periph_in,
  // Change interrupt
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic awready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic wready;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] owner;
    logic [31:0] drive_en;
    logic [31:0] filt_en;
    logic [31:0] level;
    logic [31:0] irq_mask;
    logic [31:0] irq_status;
    logic [31:0] prev_level;
    logic [2:0] settle;
    logic [31:0] pin;
    logic [31:0] pin_oe;
    logic [31:0] periph_in;
    logic irq;
  } plc_state_t;

  plc_state_t s;
  plc_state_t next_s;

  logic [31:0] pin_sync;
  logic [31:0] pin_level;
  logic [31:0] filt_active;
  logic [31:0] change;
  logic do_wr;
  logic [31:0] wr_data;
  logic [31:0] strb_mask;
  logic rd_take;

  ////////////////////////////////////////////////////////////////////////////
  // Input path: synchronise, then optional glitch filter

  plc_sync #(
    .W(PLC_LINES)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_async(i_pin),
    .o_sync(pin_sync)
  );

  // Filters apply whoever owns the line; forced off if not fitted
  assign filt_active = FILTERS_PRESENT ? s.filt_en : '0;

  plc_glitch #(
    .W(PLC_LINES)
  ) u_glitch (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_level(pin_sync),
    .i_enable(filt_active),
    .o_level(pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helper terms

  // Byte enables widened to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      strb_mask[b*8 +: 8] = {8{s.w_strb[b]}};
    end
  end

  assign do_wr = s.aw_held && s.w_held && !s.bvalid;
  assign wr_data = s.w_data & strb_mask;
  assign rd_take = i_arvalid && s.arready;
  // Edges ignored until the input pipeline holds real pin data
  assign change = (s.settle == SETTLE_CYCLES) ? (pin_level ^ s.prev_level) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_s = s;

    // Write address and data captured independently, in either order
    if (i_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = i_awaddr;
    end
    if (i_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = i_wdata;
      next_s.w_strb = i_wstrb;
    end

    // Write decode; bits of line n only touch line n
    if (do_wr) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = (s.aw_addr[1:0] != 2'h0 || s.aw_addr > OFF_LAST) ? RESP_SLVERR : RESP_OKAY;
      case (s.aw_addr)
        OFF_LINE_CLAIM: next_s.owner = s.owner | wr_data;
        OFF_LINE_RELEASE: next_s.owner = s.owner & ~wr_data;
        OFF_DRIVE_ENABLE_SET: next_s.drive_en = s.drive_en | wr_data;
        OFF_DRIVE_ENABLE_CLEAR: next_s.drive_en = s.drive_en & ~wr_data;
        OFF_GLITCH_FILTER_SET: next_s.filt_en = s.filt_en | wr_data;
        OFF_GLITCH_FILTER_CLEAR: next_s.filt_en = s.filt_en & ~wr_data;
        OFF_LEVEL_SET: next_s.level = s.level | wr_data;
        OFF_LEVEL_CLEAR: next_s.level = s.level & ~wr_data;
        OFF_CHANGE_IRQ_ENABLE: next_s.irq_mask = s.irq_mask | wr_data;
        OFF_CHANGE_IRQ_DISABLE: next_s.irq_mask = s.irq_mask & ~wr_data;
        default: next_s.owner = s.owner;
      endcase
    end
    if (s.bvalid && i_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Lines without a peripheral stay claimed
    next_s.owner = next_s.owner | LINES_NO_PERIPH;

    // Read path; one read in flight
    if (s.rvalid && i_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = (i_araddr[1:0] != 2'h0 || i_araddr > OFF_LAST) ? RESP_SLVERR : RESP_OKAY;
      case (i_araddr)
        OFF_LINE_OWNER_STATUS: next_s.rdata = s.owner;
        OFF_DRIVE_ENABLE_STATUS: next_s.rdata = s.drive_en;
        OFF_GLITCH_FILTER_STATUS: next_s.rdata = s.filt_en;
        OFF_LEVEL_PROGRAM_STATUS: next_s.rdata = s.level;
        OFF_PIN_LEVEL_STATUS: next_s.rdata = pin_level;
        OFF_CHANGE_IRQ_MASK: next_s.rdata = s.irq_mask;
        OFF_CHANGE_IRQ_STATUS: next_s.rdata = s.irq_status;
        default: next_s.rdata = '0;
      endcase
    end

    // Change status: read clears, a new edge in the same cycle wins
    next_s.irq_status = s.irq_status;
    if (rd_take && i_araddr == OFF_CHANGE_IRQ_STATUS) begin
      next_s.irq_status = '0;
    end
    next_s.irq_status = next_s.irq_status | change;

    next_s.prev_level = pin_level;
    if (s.settle != SETTLE_CYCLES) begin
      next_s.settle = s.settle + 3'h1;
    end

    // Handshake readies registered from the next occupancy
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    // Pin mux from next ownership so no stale cycle leaks through
    for (int i = 0; i < 32; i++) begin
      if (next_s.owner[i]) begin
        next_s.pin_oe[i] = next_s.drive_en[i];
        next_s.pin[i] = next_s.level[i];
        next_s.periph_in[i] = 1'b0;
      end else begin
        next_s.pin_oe[i] = i_periph_oe[i];
        next_s.pin[i] = i_periph_out[i];
        next_s.periph_in[i] = pin_level[i];
      end
    end

    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Ownership reset leaves the high lines on their peripherals
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '0;
      s.owner <= RST_LINE_OWNER;
      s.drive_en <= RST_DRIVE_ENABLE;
      s.filt_en <= RST_GLITCH_FILTER;
      s.level <= RST_LEVEL_PROGRAM;
      s.irq_mask <= RST_CHANGE_IRQ_MASK;
      s.irq_status <= RST_CHANGE_IRQ_STATUS;
    end else begin
      s <= next_s;
    end
  end

  assign o_awready = s.awready;
  assign o_wready = s.wready;
  assign o_bvalid = s.bvalid;
  assign o_bresp = s.bresp;
  assign o_arready = s.arready;
  assign o_rvalid = s.rvalid;
  assign o_rdata = s.rdata;
  assign o_rresp = s.rresp;
  assign o_pin = s.pin;
  assign o_pin_oe = s.pin_oe;
  assign o_periph_in = s.periph_in;
  assign o_irq = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // One clock domain; every check sleeps through reset
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  chk_claim_owner: assert property (
    do_wr && s.aw_addr == OFF_LINE_CLAIM |=> (s.owner & $past(wr_data)) == $past(wr_data))
    else $error("claim write did not take lines");

  chk_release_owner: assert property (
    do_wr && s.aw_addr == OFF_LINE_RELEASE
      |=> (s.owner & $past(wr_data) & ~LINES_NO_PERIPH) == '0)
    else $error("release write did not free lines");

  chk_fixed_owner: assert property (
    (s.owner & LINES_NO_PERIPH) == LINES_NO_PERIPH)
    else $error("peripheral-less line lost ownership");

  chk_periph_zero: assert property (
    (o_periph_in & s.owner) == '0)
    else $error("peripheral input not forced low");

  chk_drive_level: assert property (
    ((o_pin ^ s.level) & s.owner & s.drive_en) == '0
      && (o_pin_oe & s.owner) == (s.drive_en & s.owner))
    else $error("owned output not driving programmed level");

  chk_change_sticky: assert property (
    change != '0 |=> (s.irq_status & $past(change)) == $past(change))
    else $error("level change not recorded");

  chk_irq_gate: assert property (
    o_irq == |(s.irq_status & s.irq_mask))
    else $error("interrupt output disagrees with mask");

  chk_unused_zero: assert property (
    rd_take && (i_araddr == OFF_RESERVED_A || i_araddr == OFF_LINE_CLAIM
      || i_araddr == OFF_RESERVED_C) |=> o_rvalid && o_rdata == '0)
    else $error("unused offset read not zero");

  chk_write_resp: assert property (
    do_wr |=> o_bvalid ##0 (!o_awready && !o_wready))
    else $error("write response missing");

  chk_level_read: assert property (
    rd_take && i_araddr == OFF_PIN_LEVEL_STATUS |=> o_rdata == $past(pin_level))
    else $error("pin level read wrong");

  // Sticky change bits survive until a status read, which keeps only new edges
  chk_status_hold: assert property (
    !(rd_take && i_araddr == OFF_CHANGE_IRQ_STATUS)
      |=> (s.irq_status & $past(s.irq_status)) == $past(s.irq_status))
    else $error("change status bit lost without a read");

  chk_read_clear: assert property (
    rd_take && i_araddr == OFF_CHANGE_IRQ_STATUS |=> s.irq_status == $past(change))
    else $error("status read did not clear");

  // A hole write must leave every control register untouched
  chk_hole_write: assert property (
    do_wr && (s.aw_addr == OFF_RESERVED_A || s.aw_addr == OFF_RESERVED_B
      || s.aw_addr == OFF_RESERVED_C)
      |=> s.owner == $past(s.owner) && s.drive_en == $past(s.drive_en)
        && s.level == $past(s.level) && s.irq_mask == $past(s.irq_mask)
        && s.filt_en == $past(s.filt_en))
    else $error("reserved offset write changed state");

  // Main scenarios the bench should reach
  cov_claim: cover property (do_wr && s.aw_addr == OFF_LINE_CLAIM);
  cov_hole_write: cover property (do_wr && s.aw_addr == OFF_RESERVED_A);
  cov_slverr: cover property (o_bvalid && o_bresp == RESP_SLVERR);
  cov_irq_rise: cover property ($rose(o_irq));
  cov_status_read: cover property (rd_take && i_araddr == OFF_CHANGE_IRQ_STATUS
    && s.irq_status != '0);

endmodule : plc_top
`default_nettype wire

// *** test/plc_far_model.sv ***
// Far-side model: outside pin drivers and the on-chip peripherals.
// Assumes one clock shared with the controller.
`timescale 1ns/1ps
`default_nettype none
module plc_far_model (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [31:0] i_ext_level,
  input wire logic [31:0] i_pin_drv,
  input wire logic [31:0] i_pin_drv_oe,
  output logic [31:0] o_pin_level,
  output logic [31:0] o_periph_out,
  output logic [31:0] o_periph_oe
);
  logic [1:0] div;

  // Wire level: an enabled controller driver wins, else the outside world
  assign o_pin_level = (i_pin_drv & i_pin_drv_oe) | (i_ext_level & ~i_pin_drv_oe);

  // Peripherals drive only the upper seven lines
  assign o_periph_oe = 32'hFE000000;

  // Slow toggle, so change capture has to cope with live peripheral lines
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div <= 2'h0;
      o_periph_out <= 32'h00000000;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        o_periph_out <= o_periph_out ^ 32'hFE000000;
      end
    end
  end
endmodule : plc_far_model
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench: AXI4-Lite register tasks plus far-side pin model.
// Assumes the controller answers within a few cycles of each request.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import plc_pkg::*;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, pin, pin_drv, pin_oe, ext, p_out, p_oe, p_in, rd;
  logic [1:0] bresp, rresp, rsp;
  int n_fail, checked;

  plc_top dut (.i_sys_clk(clk), .i_nrst(nrst), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_pin(pin), .o_pin(pin_drv),
    .o_pin_oe(pin_oe), .i_periph_out(p_out), .i_periph_oe(p_oe), .o_periph_in(p_in),
    .o_irq(irq));
  plc_far_model far (.i_sys_clk(clk), .i_nrst(nrst), .i_ext_level(ext), .i_pin_drv(pin_drv),
    .i_pin_drv_oe(pin_oe), .o_pin_level(pin), .o_periph_out(p_out), .o_periph_oe(p_oe));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus tasks, closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask : chk

  // Both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    rsp = bresp;
    if (n >= 50) chk(32'h1, 32'h0, "write hang");
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rd = rdata;
    rsp = rresp;
    if (n >= 50) chk(32'h1, 32'h0, "read hang");
  endtask : rdw

  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; whole run is well under a thousand cycles
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    logic [7:0] offs [13];
    offs = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h24, 8'h2C, 8'h30,
      8'h34, 8'h40, 8'h44};
    n_fail = 0;
    checked = 0;
    nrst = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    // Response readies stay high; the master always accepts at once
    {bready, rready} = 2'h3;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    ext = 32'h00A55A34;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // Past the change-capture hold-off
    repeat (8) @(posedge clk);
    rdw(OFF_LINE_OWNER_STATUS);
    chk(rd, 32'h01FFFFFF, "owner reset");
    chk(pin_oe, 32'hFE000000, "oe reset");
    foreach (offs[i]) begin
      rdw(offs[i]);
      chk(rd, 32'h0, "wo read");
    end
    rdw(OFF_DRIVE_ENABLE_STATUS);
    chk(rd, 32'h0, "dir reset");
    rdw(OFF_LEVEL_PROGRAM_STATUS);
    chk(rd, 32'h0, "level reset");
    rdw(OFF_GLITCH_FILTER_STATUS);
    chk(rd, 32'h0, "filter reset");
    rdw(OFF_CHANGE_IRQ_MASK);
    chk(rd, 32'h0, "mask reset");
    rdw(OFF_CHANGE_IRQ_STATUS);
    chk(rd & 32'h01FFFFFF, 32'h0, "status reset");
    rdw(OFF_PIN_LEVEL_STATUS);
    chk(rd & 32'h01FFFFFF, 32'h00A55A34, "pin level");
    rdw(8'h50);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "bad read");
    $display("test done: reset and map");

    wr(OFF_RESERVED_A, 32'hFFFFFFFF);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "hole write");
    wr(8'h02, 32'hFFFFFFFF);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unaligned");
    wr(OFF_LINE_RELEASE, 32'hFFFFFFFF);
    rdw(OFF_LINE_OWNER_STATUS);
    chk(rd, LINES_NO_PERIPH, "release all");
    wr(OFF_LINE_CLAIM, 32'h00000208);
    rdw(OFF_LINE_OWNER_STATUS);
    chk(rd, LINES_NO_PERIPH | 32'h00000208, "claim");
    ext <= 32'h00000600;
    repeat (6) @(posedge clk);
    chk(p_in & 32'h00000600, 32'h00000400, "periph in");
    $display("test done: ownership");

    wr(OFF_DRIVE_ENABLE_SET, 32'h00000008);
    wr(OFF_LEVEL_SET, 32'h00000008);
    @(posedge clk);
    chk(pin_oe & 32'h0F, 32'h08, "oe");
    chk(pin_drv & 32'h0F, 32'h08, "drive");
    rdw(OFF_LEVEL_PROGRAM_STATUS);
    chk(rd, 32'h00000008, "level status");
    wr(OFF_LEVEL_CLEAR, 32'h00000008);
    wr(OFF_DRIVE_ENABLE_CLEAR, 32'h00000008);
    rdw(OFF_LEVEL_PROGRAM_STATUS);
    chk(rd, 32'h0, "level clear");
    rdw(OFF_DRIVE_ENABLE_STATUS);
    chk(rd, 32'h0, "dir clear");
    wr(OFF_GLITCH_FILTER_SET, 32'h80000001);
    rdw(OFF_GLITCH_FILTER_STATUS);
    chk(rd, 32'h80000001, "filter set");
    wr(OFF_GLITCH_FILTER_CLEAR, 32'h80000000);
    rdw(OFF_GLITCH_FILTER_STATUS);
    chk(rd, 32'h00000001, "filter clear");
    $display("test done: output and filter");

    wr(OFF_CHANGE_IRQ_ENABLE, 32'h00000020);
    rdw(OFF_CHANGE_IRQ_MASK);
    chk(rd, 32'h00000020, "mask set");
    rdw(OFF_CHANGE_IRQ_STATUS);
    ext <= 32'h00000640;
    repeat (8) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "masked line");
    ext <= 32'h00000660;
    repeat (8) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq up");
    rdw(OFF_CHANGE_IRQ_STATUS);
    chk(rd & 32'h60, 32'h60, "status");
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq down");
    rdw(OFF_CHANGE_IRQ_STATUS);
    chk(rd & 32'h60, 32'h0, "read clear");
    wr(OFF_CHANGE_IRQ_DISABLE, 32'h00000020);
    rdw(OFF_CHANGE_IRQ_MASK);
    chk(rd, 32'h0, "mask clear");
    $display("test done: interrupt");
    summarize();
  end
endmodule : testbench
`default_nettype wire
